// ===== pkg/dcb_pkg.sv
package dcb_pkg;

    // ----------------------------------------------------------------
    // Widths and depth
    // ----------------------------------------------------------------
    localparam int DATA_W    = 18;
    localparam int DEPTH_DEF = 512;
    localparam int OFS_W     = 9;

    // ----------------------------------------------------------------
    // Port A resource decode
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_FIFO    = 3'h0;
    localparam logic [2:0] ADDR_BYPASS  = 3'h1;
    localparam int         ADDR_OFS_BIT = 2;

    // Offset register index, taken from address bits 1 and 0.
    localparam logic [1:0] OFS_AB_AE = 2'h0;
    localparam logic [1:0] OFS_AB_AF = 2'h1;
    localparam logic [1:0] OFS_BA_AE = 2'h2;
    localparam logic [1:0] OFS_BA_AF = 2'h3;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [17:0] OFS_RESET  = 18'h00008;
    localparam logic [17:0] DATA_RESET = 18'h00000;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic empty_n;
        logic almost_empty_n;
        logic almost_full_n;
        logic full_n;
    } dcb_flags_s;

    localparam dcb_flags_s FLAGS_RESET = 4'h3;

    typedef struct packed {
        logic        rd_not_wr;
        logic        en_n;
        logic        oe_n;
        logic [17:0] data;
    } dcb_port_s;

endpackage

// ===== verilog/dcb_fifo_top.sv
`timescale 1ns/10ps
module dcb_fifo_top #(
    parameter int DEPTH = dcb_pkg::DEPTH_DEF
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        master_reset_n,
    input  wire logic        port_a_clock,
    input  wire logic        port_a_select_n,
    input  wire logic [2:0]  port_a_resource_addr,
    input  wire logic        port_a_read_not_write,
    input  wire logic        port_a_transfer_enable_n,
    input  wire logic        port_a_output_enable_n,
    input  wire logic [17:0] port_a_data_pins_in,
    output logic      [17:0] port_a_data_pins_out,
    output logic             port_a_data_pins_oe,
    input  wire logic        port_b_clock,
    input  wire logic        port_b_read_not_write,
    input  wire logic        port_b_transfer_enable_n,
    input  wire logic        port_b_output_enable_n,
    input  wire logic [17:0] port_b_data_pins_in,
    output logic      [17:0] port_b_data_pins_out,
    output logic             port_b_data_pins_oe,
    output logic             bypass_active_n,
    output logic             ab_empty_n,
    output logic             ab_almost_empty_n,
    output logic             ab_almost_full_n,
    output logic             ab_full_n,
    output logic             ba_empty_n,
    output logic             ba_almost_empty_n,
    output logic             ba_almost_full_n,
    output logic             ba_full_n
);

    localparam int             AW      = $clog2(DEPTH);
    localparam int             CW      = AW + 1;
    localparam logic [CW-1:0]  DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0]  ZERO_C  = '0;

    // ----------------------------------------------------------------
    // Input synchronisers and port clock edge detection
    // ----------------------------------------------------------------
    logic [25:0]        a_meta_reg, a_sync_reg;
    logic [21:0]        b_meta_reg, b_sync_reg;
    logic               rs_meta_reg, rs_sync_reg;
    logic               a_clk_d_reg, b_clk_d_reg;
    dcb_pkg::dcb_port_s a_port, b_port;

    always_ff @(posedge mclk) begin
        a_meta_reg  <= {port_a_clock, port_a_select_n, port_a_resource_addr, port_a_read_not_write,
                        port_a_transfer_enable_n, port_a_output_enable_n, port_a_data_pins_in};
        b_meta_reg  <= {port_b_clock, port_b_read_not_write, port_b_transfer_enable_n,
                        port_b_output_enable_n, port_b_data_pins_in};
        rs_meta_reg <= master_reset_n;
        a_sync_reg  <= a_meta_reg;
        b_sync_reg  <= b_meta_reg;
        rs_sync_reg <= rs_meta_reg;
        a_clk_d_reg <= a_sync_reg[25];
        b_clk_d_reg <= b_sync_reg[21];
    end

    wire       a_sel_n = a_sync_reg[24];
    wire [2:0] a_addr  = a_sync_reg[23:21];
    assign a_port = a_sync_reg[20:0];
    assign b_port = b_sync_reg[20:0];
    wire a_edge = a_sync_reg[25] & ~a_clk_d_reg;
    wire b_edge = b_sync_reg[21] & ~b_clk_d_reg;

    // Pin reset only counts while port A and both enables are idle.
    wire dev_rst = rst | (~rs_sync_reg & a_sel_n & a_port.en_n & b_port.en_n);

    // ----------------------------------------------------------------
    // Decode of the transfer requests
    // ----------------------------------------------------------------
    logic [CW-1:0] ab_wp_reg, ab_rp_reg, ba_wp_reg, ba_rp_reg;
    logic          ab_byp_valid_reg, ba_byp_valid_reg, a_byp_mode_reg, bypass_active_n_reg;
    logic [17:0]   a_in_reg, b_in_reg, a_out_reg, b_out_reg;
    logic [17:0]   ofs_reg [4];
    logic [17:0]   ab_mem [DEPTH];
    logic [17:0]   ba_mem [DEPTH];

    wire a_act     = a_edge & ~a_sel_n & ~a_port.en_n;
    wire a_wr      = a_act & ~a_port.rd_not_wr;
    wire a_rd      = a_act & a_port.rd_not_wr;
    wire a_is_fifo = (a_addr == dcb_pkg::ADDR_FIFO);
    wire a_is_byp  = (a_addr == dcb_pkg::ADDR_BYPASS);
    wire a_is_ofs  = a_addr[dcb_pkg::ADDR_OFS_BIT];
    wire b_act     = b_edge & ~b_port.en_n;
    wire b_wr      = b_act & ~b_port.rd_not_wr;
    wire b_rd      = b_act & b_port.rd_not_wr;
    wire byp_on    = ~bypass_active_n_reg;

    wire [CW-1:0] ab_cnt = ab_wp_reg - ab_rp_reg;
    wire [CW-1:0] ba_cnt = ba_wp_reg - ba_rp_reg;

    wire ab_q_wr   = a_wr & a_is_fifo & (ab_cnt != DEPTH_C);
    wire ab_q_rd   = b_rd & ~byp_on & (ab_cnt != ZERO_C);
    wire ba_q_wr   = b_wr & ~byp_on & (ba_cnt != DEPTH_C);
    wire ba_q_rd   = a_rd & a_is_fifo & (ba_cnt != ZERO_C);
    wire ab_byp_wr = a_wr & a_is_byp & ~ab_byp_valid_reg;
    wire ab_byp_rd = b_rd & byp_on & ab_byp_valid_reg;
    wire ba_byp_wr = b_wr & byp_on & ~ba_byp_valid_reg;
    wire ba_byp_rd = a_rd & a_is_byp & ba_byp_valid_reg;

    // ----------------------------------------------------------------
    // Bypass mode and bypass word holders
    // ----------------------------------------------------------------
    wire a_byp_mode_next = a_sel_n ? 1'b0 : (a_edge ? a_is_byp : a_byp_mode_reg);
    // The indicator follows port A on port B edges, but deselect forces it off at once.
    wire byp_n_next = a_sel_n ? 1'b1 : (b_edge ? ~a_byp_mode_reg : bypass_active_n_reg);
    // Leaving bypass discards any word still held in either bypass path.
    wire byp_clear  = byp_on & byp_n_next;
    wire ab_byp_valid_next = ~byp_clear & (ab_byp_wr | (ab_byp_valid_reg & ~ab_byp_rd));
    wire ba_byp_valid_next = ~byp_clear & (ba_byp_wr | (ba_byp_valid_reg & ~ba_byp_rd));

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            a_byp_mode_reg      <= 1'b0;
            bypass_active_n_reg <= 1'b1;
            ab_byp_valid_reg    <= 1'b0;
            ba_byp_valid_reg    <= 1'b0;
        end else begin
            a_byp_mode_reg      <= a_byp_mode_next;
            bypass_active_n_reg <= byp_n_next;
            ab_byp_valid_reg    <= ab_byp_valid_next;
            ba_byp_valid_reg    <= ba_byp_valid_next;
        end
    end

    // ----------------------------------------------------------------
    // Queue storage and pointers
    // ----------------------------------------------------------------
    wire [CW-1:0] ab_wp_next = ab_wp_reg + CW'(ab_q_wr);
    wire [CW-1:0] ab_rp_next = ab_rp_reg + CW'(ab_q_rd);
    wire [CW-1:0] ba_wp_next = ba_wp_reg + CW'(ba_q_wr);
    wire [CW-1:0] ba_rp_next = ba_rp_reg + CW'(ba_q_rd);
    wire [17:0]   ab_rd_word = ab_mem[ab_rp_reg[AW-1:0]];
    wire [17:0]   ba_rd_word = ba_mem[ba_rp_reg[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (ab_q_wr) begin
            ab_mem[ab_wp_reg[AW-1:0]] <= a_port.data;
        end
        if (ba_q_wr) begin
            ba_mem[ba_wp_reg[AW-1:0]] <= b_port.data;
        end
    end

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            ab_wp_reg <= '0;
            ab_rp_reg <= '0;
            ba_wp_reg <= '0;
            ba_rp_reg <= '0;
        end else begin
            ab_wp_reg <= ab_wp_next;
            ab_rp_reg <= ab_rp_next;
            ba_wp_reg <= ba_wp_next;
            ba_rp_reg <= ba_rp_next;
        end
    end

    // ----------------------------------------------------------------
    // Offset registers
    // ----------------------------------------------------------------
    generate
        for (genvar i = 0; i < 4; i++) begin : g_ofs
            always_ff @(posedge mclk) begin
                if (dev_rst) begin
                    ofs_reg[i] <= dcb_pkg::OFS_RESET;
                end else if (a_wr & a_is_ofs & (a_addr[1:0] == 2'(i))) begin
                    ofs_reg[i] <= a_port.data;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    function automatic dcb_pkg::dcb_flags_s flags_of(input logic [CW-1:0] cnt,
                                                     input logic [17:0]   n,
                                                     input logic [17:0]   m);
        dcb_pkg::dcb_flags_s f;
        f.empty_n        = (cnt != ZERO_C);
        f.almost_empty_n = (cnt > {1'b0, n[AW-1:0]});
        f.almost_full_n  = (cnt < (DEPTH_C - {1'b0, m[AW-1:0]}));
        f.full_n         = (cnt != DEPTH_C);
        return f;
    endfunction

    dcb_pkg::dcb_flags_s ab_flags_reg, ba_flags_reg;
    wire dcb_pkg::dcb_flags_s ab_q_f = flags_of(ab_wp_next - ab_rp_next, ofs_reg[dcb_pkg::OFS_AB_AE],
                                                ofs_reg[dcb_pkg::OFS_AB_AF]);
    wire dcb_pkg::dcb_flags_s ba_q_f = flags_of(ba_wp_next - ba_rp_next, ofs_reg[dcb_pkg::OFS_BA_AE],
                                                ofs_reg[dcb_pkg::OFS_BA_AF]);

    // Writer-side flags move on the writer's clock, reader-side on the reader's.
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            ab_flags_reg <= dcb_pkg::FLAGS_RESET;
            ba_flags_reg <= dcb_pkg::FLAGS_RESET;
        end else begin
            if (a_edge) begin
                ab_flags_reg.full_n         <= a_byp_mode_next ? ~ab_byp_valid_next : ab_q_f.full_n;
                ab_flags_reg.almost_full_n  <= ab_q_f.almost_full_n;
                ba_flags_reg.empty_n        <= a_byp_mode_next ? ba_byp_valid_next : ba_q_f.empty_n;
                ba_flags_reg.almost_empty_n <= ba_q_f.almost_empty_n;
            end
            if (b_edge) begin
                ab_flags_reg.empty_n        <= ~byp_n_next ? ab_byp_valid_next : ab_q_f.empty_n;
                ab_flags_reg.almost_empty_n <= ab_q_f.almost_empty_n;
                ba_flags_reg.full_n         <= ~byp_n_next ? ~ba_byp_valid_next : ba_q_f.full_n;
                ba_flags_reg.almost_full_n  <= ba_q_f.almost_full_n;
            end
        end
    end

    // ----------------------------------------------------------------
    // Input, output and enable registers
    // ----------------------------------------------------------------
    wire [17:0] a_out_sel = a_is_ofs ? ofs_reg[a_addr[1:0]] :
                            a_is_byp ? b_in_reg : ba_rd_word;
    wire        a_out_ld  = a_rd & (a_is_ofs | a_is_byp | ba_q_rd);
    wire        b_out_ld  = ab_q_rd | ab_byp_rd;
    wire        b_in_ld   = b_wr & ~(byp_on & ba_byp_valid_reg);

    logic a_oe_reg, b_oe_reg;

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            a_in_reg  <= dcb_pkg::DATA_RESET;
            b_in_reg  <= dcb_pkg::DATA_RESET;
            a_out_reg <= dcb_pkg::DATA_RESET;
            b_out_reg <= dcb_pkg::DATA_RESET;
            a_oe_reg  <= 1'b0;
            b_oe_reg  <= 1'b0;
        end else begin
            if (ab_byp_wr) a_in_reg <= a_port.data;
            if (b_in_ld) b_in_reg <= b_port.data;
            if (a_out_ld) a_out_reg <= a_out_sel;
            if (b_out_ld) b_out_reg <= ab_byp_rd ? a_in_reg : ab_rd_word;
            a_oe_reg <= ~a_sel_n & a_port.rd_not_wr & ~a_port.oe_n;
            b_oe_reg <= b_port.rd_not_wr & ~b_port.oe_n;
        end
    end

    assign port_a_data_pins_out = a_out_reg;
    assign port_a_data_pins_oe  = a_oe_reg;
    assign port_b_data_pins_out = b_out_reg;
    assign port_b_data_pins_oe  = b_oe_reg;
    assign bypass_active_n      = bypass_active_n_reg;
    assign ab_empty_n           = ab_flags_reg.empty_n;
    assign ab_almost_empty_n    = ab_flags_reg.almost_empty_n;
    assign ab_almost_full_n     = ab_flags_reg.almost_full_n;
    assign ab_full_n            = ab_flags_reg.full_n;
    assign ba_empty_n           = ba_flags_reg.empty_n;
    assign ba_almost_empty_n    = ba_flags_reg.almost_empty_n;
    assign ba_almost_full_n     = ba_flags_reg.almost_full_n;
    assign ba_full_n            = ba_flags_reg.full_n;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (dev_rst);

    property p_q_read;
        ba_q_rd |=> (a_out_reg == $past(ba_rd_word)) && (ba_rp_reg == $past(ba_rp_reg) + 1'b1);
    endproperty
    a_q_read: assert property (p_q_read) else $error("queue read did not load word");
    property p_byp_read;
        (a_rd & a_is_byp) |=> a_out_reg == $past(b_in_reg);
    endproperty
    a_byp_read: assert property (p_byp_read) else $error("bypass read wrong word");
    property p_ofs_read;
        (a_rd & a_is_ofs) |=> a_out_reg == $past(ofs_reg[a_addr[1:0]]);
    endproperty
    a_ofs_read: assert property (p_ofs_read) else $error("offset read wrong value");
    property p_rd_hold;
        (a_edge & a_port.rd_not_wr & a_port.en_n) |=> $stable(a_out_reg) && $stable(ba_rp_reg);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("disabled read changed state");
    property p_desel;
        a_sel_n |=> bypass_active_n_reg && !a_byp_mode_reg;
    endproperty
    a_desel: assert property (p_desel) else $error("bypass active while deselected");
    property p_ab_byp_full;
        ab_byp_wr |=> !ab_flags_reg.full_n && ab_byp_valid_reg;
    endproperty
    a_ab_byp_full: assert property (p_ab_byp_full) else $error("full not low after bypass write");
    property p_ab_byp_empty;
        (b_edge & byp_on & ~byp_n_next & ab_byp_valid_reg & ~b_rd) |=> ab_flags_reg.empty_n;
    endproperty
    a_ab_byp_empty: assert property (p_ab_byp_empty) else $error("empty not high with word waiting");
    property p_ab_byp_rd;
        ab_byp_rd |=> (b_out_reg == $past(a_in_reg)) && !ab_flags_reg.empty_n;
    endproperty
    a_ab_byp_rd: assert property (p_ab_byp_rd) else $error("bypass read by port B failed");
    property p_oe;
        ##1 port_b_data_pins_oe == $past(b_port.rd_not_wr & ~b_port.oe_n);
    endproperty
    a_oe: assert property (p_oe) else $error("port B enable mismatch");
    property p_empty_flag;
        (b_edge & byp_n_next & ~byp_on & ~ab_q_f.empty_n) |=> !ab_flags_reg.empty_n && !ab_flags_reg.almost_empty_n;
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("empty queue flags wrong");
    c_ab_bypass: cover property (ab_byp_wr ##[1:200] ab_byp_rd);
    c_queue_full: cover property (!ab_flags_reg.full_n && !a_byp_mode_reg);
    c_both_byp_reads: cover property (ab_byp_rd & ba_byp_rd);
    c_byp_end: cover property (byp_on ##1 !byp_on);

endmodule

// ===== tb/dcb_port_b_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port B processor model
// ----------------------------------------------------------------
module dcb_port_b_model (
    input  wire logic        mclk,
    output logic             port_b_clock,
    output logic             port_b_read_not_write,
    output logic             port_b_transfer_enable_n,
    output logic             port_b_output_enable_n,
    output logic      [17:0] port_b_data_pins_in
);
    initial begin
        port_b_clock = 1'b0;
        port_b_read_not_write = 1'b1;
        port_b_transfer_enable_n = 1'b1;
        port_b_output_enable_n = 1'b1;
        port_b_data_pins_in = 18'h155aa;
    end

    // One 120 ns port B clock period; the clock stands still between transfers.
    // Released data pins show the inverse of their last value, never a stale word.
    task automatic xfer(input logic rd, input logic en_n, input logic [17:0] d);
        @(posedge mclk);
        port_b_read_not_write <= rd;
        port_b_transfer_enable_n <= en_n;
        port_b_output_enable_n <= ~rd;
        port_b_data_pins_in <= rd ? ~port_b_data_pins_in : d;
        repeat (5) @(posedge mclk);
        port_b_clock <= 1'b1;
        repeat (12) @(posedge mclk);
        port_b_clock <= 1'b0;
        port_b_transfer_enable_n <= 1'b1;
        port_b_output_enable_n <= 1'b1;
        port_b_data_pins_in <= ~port_b_data_pins_in;
        repeat (7) @(negedge mclk);
    endtask
endmodule

// ===== tb/dcb_fifo_top_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("unexpected %0t %h %h", $time, g, e); end end
module dcb_fifo_top_bench;
    localparam int DEPTH = 256;
    logic        mclk, rst, master_reset_n, port_a_clock, port_a_select_n, port_a_read_not_write;
    logic        port_a_transfer_enable_n, port_a_output_enable_n, port_a_data_pins_oe, a_oe;
    logic [2:0]  port_a_resource_addr;
    logic [17:0] port_a_data_pins_in, port_a_data_pins_out, port_b_data_pins_in, port_b_data_pins_out, a_q;
    logic        port_b_clock, port_b_read_not_write, port_b_transfer_enable_n, port_b_output_enable_n;
    logic        port_b_data_pins_oe, bypass_active_n, ab_empty_n, ab_almost_empty_n, ab_almost_full_n, ab_full_n;
    logic        ba_empty_n, ba_almost_empty_n, ba_almost_full_n, ba_full_n;
    int          bad_count;
    int          check_count;
    wire  [3:0]  ab_flags = {ab_empty_n, ab_almost_empty_n, ab_almost_full_n, ab_full_n};

    dcb_fifo_top #(.DEPTH(DEPTH)) dcb_fifo_top_inst (.mclk, .rst, .master_reset_n, .port_a_clock, .port_a_select_n,
        .port_a_resource_addr, .port_a_read_not_write, .port_a_transfer_enable_n, .port_a_output_enable_n,
        .port_a_data_pins_in, .port_a_data_pins_out, .port_a_data_pins_oe, .port_b_clock, .port_b_read_not_write,
        .port_b_transfer_enable_n, .port_b_output_enable_n, .port_b_data_pins_in, .port_b_data_pins_out,
        .port_b_data_pins_oe, .bypass_active_n, .ab_empty_n, .ab_almost_empty_n, .ab_almost_full_n, .ab_full_n,
        .ba_empty_n, .ba_almost_empty_n, .ba_almost_full_n, .ba_full_n);
    dcb_port_b_model dcb_port_b_model_inst (.mclk, .port_b_clock, .port_b_read_not_write,
        .port_b_transfer_enable_n, .port_b_output_enable_n, .port_b_data_pins_in);

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic a_cyc(input logic [2:0] ad, input logic rd, input logic en_n, input logic [17:0] d);
        @(posedge mclk);
        port_a_resource_addr <= ad;
        port_a_read_not_write <= rd;
        port_a_transfer_enable_n <= en_n;
        port_a_output_enable_n <= ~rd;
        port_a_data_pins_in <= rd ? ~port_a_data_pins_in : d;
        repeat (5) @(posedge mclk);
        port_a_clock <= 1'b1;
        repeat (11) @(negedge mclk);
        a_q = port_a_data_pins_out;
        a_oe = port_a_data_pins_oe;
        @(posedge mclk);
        port_a_clock <= 1'b0;
        port_a_transfer_enable_n <= 1'b1;
        port_a_output_enable_n <= 1'b1;
        port_a_data_pins_in <= ~port_a_data_pins_in;
        repeat (7) @(negedge mclk);
    endtask

    task automatic b_cyc(input logic rd, input logic en_n, input logic [17:0] d);
        dcb_port_b_model_inst.xfer(rd, en_n, d);
    endtask

    task automatic test_done();
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        test_done();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, port_a_select_n, port_a_transfer_enable_n, port_a_output_enable_n, port_a_read_not_write} = 5'h1f;
        {master_reset_n, port_a_clock, port_a_resource_addr} = 5'h00;
        port_a_data_pins_in = 18'h2aa55;
        bad_count = 0;
        check_count = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        master_reset_n <= 1'b1;
        port_a_select_n <= 1'b0;
        repeat (8) @(negedge mclk);
        `CHK({ab_flags, ba_empty_n, ba_almost_empty_n, ba_almost_full_n, ba_full_n}, 8'h33)
        for (int i = 4; i < 8; i++) begin
            a_cyc(3'(i), 1'b1, 1'b0, 18'h0);
            `CHK(a_q, dcb_pkg::OFS_RESET)
        end
        `CHK(a_oe, 1'b1)
        a_cyc(3'h4, 1'b0, 1'b0, 18'h3fe02);
        `CHK(a_oe, 1'b0)
        a_cyc(3'h4, 1'b1, 1'b0, 18'h0);
        `CHK(a_q, 18'h3fe02)
        for (int i = 0; i < 3; i++) begin
            a_cyc(3'h0, 1'b0, 1'b0, 18'h10 + 18'(i));
            b_cyc(1'b1, 1'b1, 18'h0);
            `CHK(ab_flags[3:2], (i < 2) ? 2'b10 : 2'b11)
        end
        for (int i = 0; i < 3; i++) begin
            b_cyc(1'b1, 1'b0, 18'h0);
            `CHK(port_b_data_pins_out, 18'h10 + 18'(i))
        end
        `CHK(ab_empty_n, 1'b0)
        b_cyc(1'b0, 1'b0, 18'h20);
        b_cyc(1'b0, 1'b0, 18'h21);
        a_cyc(3'h0, 1'b1, 1'b1, 18'h0);
        `CHK({a_q, ba_empty_n}, {18'h3fe02, 1'b1})
        for (int i = 0; i < 2; i++) begin
            a_cyc(3'h0, 1'b1, 1'b0, 18'h0);
            `CHK(a_q, 18'h20 + 18'(i))
        end
        `CHK(ba_empty_n, 1'b0)
        a_cyc(3'h1, 1'b0, 1'b0, 18'h2aaaa);
        `CHK(ab_full_n, 1'b0)
        a_cyc(3'h1, 1'b0, 1'b0, 18'h15555);
        b_cyc(1'b1, 1'b1, 18'h0);
        `CHK({bypass_active_n, ab_empty_n}, 2'b01)
        b_cyc(1'b0, 1'b0, 18'h0c3c3);
        `CHK(ba_full_n, 1'b0)
        fork
            a_cyc(3'h1, 1'b1, 1'b0, 18'h0);
            b_cyc(1'b1, 1'b0, 18'h0);
            begin
                repeat (10) @(negedge mclk);
                `CHK(port_b_data_pins_oe, 1'b1)
            end
        join
        `CHK(port_b_data_pins_oe, 1'b0)
        `CHK({a_q, port_b_data_pins_out}, {18'h0c3c3, 18'h2aaaa})
        `CHK({ab_empty_n, ba_empty_n}, 2'b00)
        a_cyc(3'h1, 1'b1, 1'b1, 18'h0);
        `CHK(ab_full_n, 1'b1)
        b_cyc(1'b1, 1'b1, 18'h0);
        `CHK({ab_empty_n, ba_full_n}, 2'b01)
        a_cyc(3'h0, 1'b1, 1'b1, 18'h0);
        b_cyc(1'b1, 1'b1, 18'h0);
        `CHK(bypass_active_n, 1'b1)
        a_cyc(3'h1, 1'b0, 1'b0, 18'h00777);
        b_cyc(1'b1, 1'b1, 18'h0);
        `CHK(bypass_active_n, 1'b0)
        @(posedge mclk);
        port_a_select_n <= 1'b1;
        repeat (6) @(negedge mclk);
        `CHK(bypass_active_n, 1'b1)
        @(posedge mclk);
        port_a_select_n <= 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            a_cyc(3'h0, 1'b0, 1'b0, 18'(i));
            if (i >= DEPTH - 10) begin
                `CHK(ab_flags[1:0], (i == DEPTH - 1) ? 2'b00 : ((i >= DEPTH - 9) ? 2'b01 : 2'b11))
            end
        end
        a_cyc(3'h0, 1'b0, 1'b0, 18'h3ffff);
        b_cyc(1'b1, 1'b0, 18'h0);
        `CHK(port_b_data_pins_out, 18'h0)
        @(posedge mclk);
        port_a_select_n <= 1'b1;
        master_reset_n <= 1'b0;
        repeat (6) @(posedge mclk);
        master_reset_n <= 1'b1;
        port_a_select_n <= 1'b0;
        repeat (6) @(negedge mclk);
        `CHK(ab_flags, 4'h3)
        a_cyc(3'h4, 1'b1, 1'b0, 18'h0);
        `CHK(a_q, dcb_pkg::OFS_RESET)
        test_done();
    end
endmodule
